//--- hpfg_consts.svh
// Constants for the host port with fast address-mask gate.
// Included by hpfg_pkg.sv and hpfg_host_port.sv.
`ifndef HPFG_CONSTS_SVH
`define HPFG_CONSTS_SVH

`define HPFG_ADDR_CONTROL    16'hfff0
`define HPFG_ADDR_SYSCTL     16'hffc4
`define HPFG_ADDR_IN_ONE     16'hffb0
`define HPFG_ADDR_OUT_ONE    16'hffb1
`define HPFG_ADDR_STAT_ONE   16'hffb2
`define HPFG_ADDR_IN_TWO     16'hffb4
`define HPFG_ADDR_OUT_TWO    16'hffb5
`define HPFG_ADDR_STAT_TWO   16'hffb6
`define HPFG_ADDR_GATE_PORT  16'hffb8

`define HPFG_BIT_FAST_EN     0
`define HPFG_BIT_DIR         0
`define HPFG_BIT_IRQ_EN_ONE  1
`define HPFG_BIT_PORT_EN     1
`define HPFG_BIT_GATE        1
`define HPFG_BIT_CMD         3
`define HPFG_BIT_IN_FULL     1
`define HPFG_BIT_OUT_FULL    0
`define HPFG_USER_MASK       8'hf4

`define HPFG_CMD_GATE        8'hd1
`define HPFG_CMD_NULL        8'hff
`define HPFG_RESET_BYTE      8'h00
`define HPFG_GATE_INIT       1'b1
`define HPFG_PIN_IDLE        5'h1f

`endif

//--- hpfg_pkg.sv
// Types for the host port with fast address-mask gate.
// Assumes hpfg_consts.svh sits in the same folder.
`include "hpfg_consts.svh"

package hpfg_pkg;
   typedef enum logic [1:0] {
      HPFG_IDLE = 2'b01,
      HPFG_WAIT = 2'b10
   } hpfg_gate_state_t;
endpackage : hpfg_pkg

//--- hpfg_host_port.sv
// Host port with two channels and a hardware fast address-mask gate.
// Assumes host pins asynchronous to clk; slave CPU on a same-clock strobe bus.
//
// How it works
// - Port acts only while port enable set
// - Channel one read gives out byte or status
// - Channel one write captures byte, command or data
// - Channel two read gives out byte or status
// - Channel two write captures byte, command or data
// - Fast gate enable selects hardware gate control
// - Fast gate output starts at logic one
// - Only channel one host writes drive the fast gate
// - Data after D1 with bit one sets gate
// - Data after D1 with bit one clear clears
// - D1, data, FF consumed without interrupt flag
// - Other command after pair raises interrupt flag
// - Non-D1 command after D1 cancels, raises flag
// - Write latches command/data line into status
// - Input full set by host, cleared by read
// - Output full set by slave, cleared by host
// - Channel one input-full interrupt needs enable and full; channel two needs full only
`timescale 1ns/1ps
`default_nettype none
`include "hpfg_consts.svh"

module hpfg_host_port
   import hpfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output var  logic [7:0]  regRdata,
   input  wire logic        channel_one_select_n,
   input  wire logic        channel_two_select_n,
   input  wire logic        host_read_strobe_n,
   input  wire logic        host_write_strobe_n,
   input  wire logic        host_cmd_data_line,
   input  wire logic [7:0]  hostDataIn,
   output var  logic [7:0]  hostDataOut,
   output logic             hostDataOe,
   output var  logic        address_mask_gate_out,
   output logic             gatePinOe,
   output logic             in_full_irq_one,
   output logic             inFullIrqTwo
);

   ////////////////////////////////////////////////////////////////////////////
   // Host pin synchronisers
   logic [4:0] pinMeta;
   logic [4:0] pinSync;
   logic [7:0] dataMeta;
   logic [7:0] dataSync;
   logic       wrPrev;
   logic       rdPrev;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta  <= `HPFG_PIN_IDLE;
         pinSync  <= `HPFG_PIN_IDLE;
         dataMeta <= `HPFG_RESET_BYTE;
         dataSync <= `HPFG_RESET_BYTE;
      end else begin
         pinMeta  <= {channel_one_select_n, channel_two_select_n, host_read_strobe_n,
                      host_write_strobe_n, host_cmd_data_line};
         pinSync  <= pinMeta;
         dataMeta <= hostDataIn;
         dataSync <= dataMeta;
      end
   end

   logic sel1N;
   logic sel2N;
   logic rdN;
   logic wrN;
   logic cmdLine;
   assign {sel1N, sel2N, rdN, wrN, cmdLine} = pinSync;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPrev <= 1'b1;
         rdPrev <= 1'b1;
      end else begin
         wrPrev <= wrN;
         rdPrev <= rdN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slave registers
   logic [7:0] system_control_reg;
   logic [7:0] host_port_control;
   logic [7:0] in_byte_one;
   logic [7:0] in_byte_two;
   logic [7:0] out_byte_one;
   logic [7:0] out_byte_two;
   logic [7:0] stat_one;
   logic [7:0] stat_two;
   logic       gate_pin_direction;
   logic       softGate;
   logic       fastGate;

   logic portOn;
   logic fast_gate_enable;
   logic in_full_irq_enable_one;
   assign portOn                 = system_control_reg[`HPFG_BIT_PORT_EN];
   assign fast_gate_enable       = host_port_control[`HPFG_BIT_FAST_EN];
   assign in_full_irq_enable_one = host_port_control[`HPFG_BIT_IRQ_EN_ONE];

   // Host cycle decode; both strobes low is treated as idle
   function automatic logic chanSel(input logic on, input logic ownN, input logic otherN);
      chanSel = on && !ownN && otherN;
   endfunction : chanSel

   // A strobe ends only if the other strobe stayed high across the edge
   function automatic logic strobeEnd(input logic nowN, input logic wasN, input logic othN,
                                      input logic othWasN);
      strobeEnd = nowN && !wasN && othN && othWasN;
   endfunction : strobeEnd

   logic ch1;
   logic ch2;
   logic bothLow;
   logic hostWrEnd;
   logic hostRdEnd;
   logic wr1;
   logic wr2;
   logic rdOut1;
   logic rdOut2;
   assign ch1       = chanSel(portOn, sel1N, sel2N);
   assign ch2       = chanSel(portOn, sel2N, sel1N);
   assign bothLow   = !rdN && !wrN;
   assign hostWrEnd = strobeEnd(wrN, wrPrev, rdN, rdPrev);
   assign hostRdEnd = strobeEnd(rdN, rdPrev, wrN, wrPrev);
   assign wr1       = ch1 && hostWrEnd;
   assign wr2       = ch2 && hostWrEnd;
   assign rdOut1    = ch1 && hostRdEnd && !cmdLine;
   assign rdOut2    = ch2 && hostRdEnd && !cmdLine;

   logic swWr;
   logic swRd;
   function automatic logic hit(input logic [15:0] a, input logic [15:0] want);
      hit = (a == want);
   endfunction : hit
   assign swWr = regWrite;
   assign swRd = regRead;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         system_control_reg <= `HPFG_RESET_BYTE;
         host_port_control  <= `HPFG_RESET_BYTE;
         gate_pin_direction <= 1'b0;
         softGate           <= `HPFG_GATE_INIT;
      end else if (swWr) begin
         if (hit(regAddr, `HPFG_ADDR_SYSCTL)) system_control_reg <= regWdata;
         if (hit(regAddr, `HPFG_ADDR_CONTROL)) host_port_control <= regWdata;
         if (hit(regAddr, `HPFG_ADDR_GATE_PORT)) begin
            gate_pin_direction <= regWdata[`HPFG_BIT_DIR];
            softGate           <= regWdata[`HPFG_BIT_GATE];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_byte_one <= `HPFG_RESET_BYTE;
      end else if (wr1) begin
         in_byte_one <= dataSync;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_byte_two <= `HPFG_RESET_BYTE;
      end else if (wr2) begin
         in_byte_two <= dataSync;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_byte_one <= `HPFG_RESET_BYTE;
      end else if (swWr && hit(regAddr, `HPFG_ADDR_OUT_ONE)) begin
         out_byte_one <= regWdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_byte_two <= `HPFG_RESET_BYTE;
      end else if (swWr && hit(regAddr, `HPFG_ADDR_OUT_TWO)) begin
         out_byte_two <= regWdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fast gate sequencer
   hpfg_gate_state_t gateState;
   logic             swallow;
   logic             isGateCmd;
   logic             isNullCmd;
   assign isGateCmd = (dataSync == `HPFG_CMD_GATE);
   assign isNullCmd = (dataSync == `HPFG_CMD_NULL);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gateState <= HPFG_IDLE;
         fastGate  <= `HPFG_GATE_INIT;
      end else if (!fast_gate_enable) begin
         gateState <= HPFG_IDLE;
         fastGate  <= `HPFG_GATE_INIT;
      end else if (wr1) begin
         case (gateState)
            HPFG_IDLE: begin
               if (cmdLine && isGateCmd) gateState <= HPFG_WAIT;
            end
            HPFG_WAIT: begin
               if (!cmdLine) begin
                  fastGate  <= dataSync[`HPFG_BIT_GATE];
                  gateState <= HPFG_IDLE;
               end else if (!isGateCmd) begin
                  gateState <= HPFG_IDLE;
               end
            end
            default: gateState <= HPFG_IDLE;
         endcase
      end
   end

   // Bytes the hardware consumes raise no input-full flag
   always_comb begin
      swallow = 1'b0;
      if (fast_gate_enable) begin
         if (cmdLine && isGateCmd) swallow = 1'b1;
         else if (cmdLine && isNullCmd && gateState != HPFG_WAIT) swallow = 1'b1;
         else if (!cmdLine && gateState == HPFG_WAIT) swallow = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status registers; host set wins over slave clear
   logic rdIn1;
   logic rdIn2;
   logic wrOut1;
   logic wrOut2;
   assign rdIn1  = swRd && hit(regAddr, `HPFG_ADDR_IN_ONE);
   assign rdIn2  = swRd && hit(regAddr, `HPFG_ADDR_IN_TWO);
   assign wrOut1 = swWr && hit(regAddr, `HPFG_ADDR_OUT_ONE);
   assign wrOut2 = swWr && hit(regAddr, `HPFG_ADDR_OUT_TWO);

   // Slave writes reach only the user bits
   function automatic logic [7:0] userMerge(input logic [7:0] old, input logic [7:0] wdata);
      userMerge = (old & ~`HPFG_USER_MASK) | (wdata & `HPFG_USER_MASK);
   endfunction : userMerge

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_one <= `HPFG_RESET_BYTE;
      end else begin
         if (swWr && hit(regAddr, `HPFG_ADDR_STAT_ONE))
            stat_one <= userMerge(stat_one, regWdata);
         if (wr1) stat_one[`HPFG_BIT_CMD] <= cmdLine;
         if (wr1 && !swallow) stat_one[`HPFG_BIT_IN_FULL] <= 1'b1;
         else if (rdIn1) stat_one[`HPFG_BIT_IN_FULL] <= 1'b0;
         if (wrOut1) stat_one[`HPFG_BIT_OUT_FULL] <= 1'b1;
         else if (rdOut1) stat_one[`HPFG_BIT_OUT_FULL] <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_two <= `HPFG_RESET_BYTE;
      end else begin
         if (swWr && hit(regAddr, `HPFG_ADDR_STAT_TWO))
            stat_two <= userMerge(stat_two, regWdata);
         if (wr2) stat_two[`HPFG_BIT_CMD] <= cmdLine;
         if (wr2) stat_two[`HPFG_BIT_IN_FULL] <= 1'b1;
         else if (rdIn2) stat_two[`HPFG_BIT_IN_FULL] <= 1'b0;
         if (wrOut2) stat_two[`HPFG_BIT_OUT_FULL] <= 1'b1;
         else if (rdOut2) stat_two[`HPFG_BIT_OUT_FULL] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         address_mask_gate_out <= `HPFG_GATE_INIT;
      end else begin
         address_mask_gate_out <= fast_gate_enable ? fastGate : softGate;
      end
   end
   assign gatePinOe = gate_pin_direction;

   assign in_full_irq_one = in_full_irq_enable_one && stat_one[`HPFG_BIT_IN_FULL];
   assign inFullIrqTwo    = stat_two[`HPFG_BIT_IN_FULL];

   // Status on the command line, data byte otherwise
   function automatic logic [7:0] hostPick(input logic cd, input logic [7:0] stat,
                                           input logic [7:0] data);
      hostPick = cd ? stat : data;
   endfunction : hostPick

   // Host read data, driven while a selected read strobe is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostDataOut <= `HPFG_RESET_BYTE;
      end else if (ch1) begin
         hostDataOut <= hostPick(cmdLine, stat_one, out_byte_one);
      end else if (ch2) begin
         hostDataOut <= hostPick(cmdLine, stat_two, out_byte_two);
      end
   end
   assign hostDataOe = (ch1 || ch2) && !rdN && wrN && !bothLow;

   // Slave read port, data one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= `HPFG_RESET_BYTE;
      end else if (swRd) begin
         case (regAddr)
            `HPFG_ADDR_SYSCTL:    regRdata <= system_control_reg;
            `HPFG_ADDR_CONTROL:   regRdata <= host_port_control;
            `HPFG_ADDR_IN_ONE:    regRdata <= in_byte_one;
            `HPFG_ADDR_OUT_ONE:   regRdata <= out_byte_one;
            `HPFG_ADDR_STAT_ONE:  regRdata <= stat_one;
            `HPFG_ADDR_IN_TWO:    regRdata <= in_byte_two;
            `HPFG_ADDR_OUT_TWO:   regRdata <= out_byte_two;
            `HPFG_ADDR_STAT_TWO:  regRdata <= stat_two;
            `HPFG_ADDR_GATE_PORT: regRdata <= {6'h00, softGate, gate_pin_direction};
            default:              regRdata <= `HPFG_RESET_BYTE;
         endcase
      end else begin
         regRdata <= `HPFG_RESET_BYTE;
      end
   end

endmodule : hpfg_host_port
`default_nettype wire

//--- hpfg_host_port_checker.sv
// Assertions on the host port pins and the slave register bus.
// Bound to hpfg_host_port; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "hpfg_consts.svh"
module hpfg_host_port_checker (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [15:0] regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic        channel_two_select_n,
   input wire logic        host_read_strobe_n,
   input wire logic        host_write_strobe_n,
   input wire logic        hostDataOe,
   input wire logic        address_mask_gate_out,
   input wire logic        gatePinOe,
   input wire logic        in_full_irq_one,
   input wire logic        inFullIrqTwo
);
   logic [2:0] sinceWr;
   logic       wrTwo;

   // Cycles since the host write strobe went high, and its channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sinceWr <= 3'h7;
         wrTwo   <= 1'b0;
      end else if (!host_write_strobe_n) begin
         sinceWr <= 3'h0;
         wrTwo   <= !channel_two_select_n;
      end else if (sinceWr != 3'h7) begin
         sinceWr <= sinceWr + 3'h1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   oe_read_only_a: assert property (
      hostDataOe |-> (!$past(host_read_strobe_n, 2) || !$past(host_read_strobe_n, 3)))
      else $error("Host bus driven outside a read");
   oe_release_a: assert property (
      $rose(host_read_strobe_n) |-> ##4 !hostDataOe)
      else $error("Host bus still driven after read end");
   gate_cause_a: assert property (
      $changed(address_mask_gate_out) |-> $past(regWrite) || $past(regWrite, 2) ||
         (sinceWr inside {[1:6]} && !wrTwo))
      else $error("Gate moved without a channel one write");
   irq_one_rise_a: assert property (
      $rose(in_full_irq_one) |-> $past(regWrite) || (sinceWr inside {[1:6]} && !wrTwo))
      else $error("Channel one request without cause");
   irq_one_fall_a: assert property (
      $fell(in_full_irq_one) |-> $past(regRead) || $past(regWrite))
      else $error("Channel one request dropped without cause");
   irq_two_rise_a: assert property (
      $rose(inFullIrqTwo) |-> sinceWr inside {[1:6]} && wrTwo)
      else $error("Channel two full without a channel two write");
   irq_two_fall_a: assert property (
      $fell(inFullIrqTwo) |-> $past(regRead) && $past(regAddr) == `HPFG_ADDR_IN_TWO)
      else $error("Channel two full cleared without a read");
   dir_cause_a: assert property (
      $changed(gatePinOe) |-> $past(regWrite) && $past(regAddr) == `HPFG_ADDR_GATE_PORT)
      else $error("Gate direction moved without a write");
endmodule : hpfg_host_port_checker

bind hpfg_host_port hpfg_host_port_checker i_hpfg_host_port_checker (.clk, .rst_n, .regAddr,
   .regWrite, .regRead, .channel_two_select_n, .host_read_strobe_n, .host_write_strobe_n,
   .hostDataOe, .address_mask_gate_out, .gatePinOe, .in_full_irq_one, .inFullIrqTwo);
`default_nettype wire

//--- hpfg_host_model.sv
// Host processor model on the parallel host bus.
// Assumes the bench clock; pins move just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module hpfg_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] hostDataOut,
   input  wire logic       hostDataOe,
   output var  logic       channel_one_select_n,
   output var  logic       channel_two_select_n,
   output var  logic       host_read_strobe_n,
   output var  logic       host_write_strobe_n,
   output var  logic       host_cmd_data_line,
   output var  logic [7:0] hostDataIn
);
   initial begin
      channel_one_select_n = 1'b1;
      channel_two_select_n = 1'b1;
      host_read_strobe_n   = 1'b1;
      host_write_strobe_n  = 1'b1;
      host_cmd_data_line   = 1'b0;
      hostDataIn           = 8'h00;
   end
   task automatic sel(input logic two, input logic cd);
      @(posedge clk);
      channel_one_select_n <= two;
      channel_two_select_n <= !two;
      host_cmd_data_line   <= cd;
   endtask
   // Hold past the strobe for the sync delay, then deselect and drive the inverted byte
   task automatic freeBus(input logic [7:0] d);
      repeat (5) @(posedge clk);
      channel_one_select_n <= 1'b1;
      channel_two_select_n <= 1'b1;
      hostDataIn           <= ~d;
      repeat (6) @(posedge clk);
   endtask
   task automatic hostWrite(input logic two, input logic cd, input logic [7:0] d,
                            input logic both);
      sel(two, cd);
      hostDataIn <= d;
      @(posedge clk);
      host_write_strobe_n <= 1'b0;
      host_read_strobe_n  <= !both;
      repeat (6) @(posedge clk);
      host_write_strobe_n <= 1'b1;
      host_read_strobe_n  <= 1'b1;
      freeBus(d);
   endtask
   task automatic hostRead(input logic two, input logic cd, output logic [8:0] got);
      sel(two, cd);
      @(posedge clk);
      host_read_strobe_n <= 1'b0;
      repeat (6) @(posedge clk);
      got = {hostDataOe, hostDataOut};
      host_read_strobe_n <= 1'b1;
      freeBus(hostDataIn);
   endtask
endmodule : hpfg_host_model
`default_nettype wire

//--- hpfg_host_port_tb.sv
// Self-checking bench for the host port with fast gate.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "hpfg_consts.svh"
module hpfg_host_port_tb;
   localparam logic [11:0] STEPS [16] = '{12'hcd1, 12'h000, 12'h8ff, 12'h8d1, 12'h402,
      12'hcff, 12'hcd1, 12'h000, 12'haaa, 12'h8d1, 12'haff, 12'h8d1, 12'ha55, 12'h8d1,
      12'h8d1, 12'h402};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0]  regWdata = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic        rdPend = 1'b0;
   logic [31:0] seed = 32'h00000d1d;
   logic [7:0]  expQ [$];
   int          errors = 0;
   int          totalChecks = 0;
   int          cycles = 0;
   wire  [7:0]  regRdata, hostDataOut, hostDataIn;
   wire         channel_one_select_n, channel_two_select_n, host_read_strobe_n;
   wire         host_write_strobe_n, host_cmd_data_line, hostDataOe, address_mask_gate_out;
   wire         gatePinOe, in_full_irq_one, inFullIrqTwo;

   hpfg_host_port i_hpfg_host_port (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
      .regRdata, .channel_one_select_n, .channel_two_select_n, .host_read_strobe_n,
      .host_write_strobe_n, .host_cmd_data_line, .hostDataIn, .hostDataOut, .hostDataOe,
      .address_mask_gate_out, .gatePinOe, .in_full_irq_one, .inFullIrqTwo);
   hpfg_host_model i_hpfg_host_model (.clk, .hostDataOut, .hostDataOe, .channel_one_select_n,
      .channel_two_select_n, .host_read_strobe_n, .host_write_strobe_n, .host_cmd_data_line,
      .hostDataIn);

   always #10 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      totalChecks++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask : chk
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      regRead <= 1'b0;
   endtask : rd
   task automatic hostChk(input logic two, input logic cd, input logic [7:0] e);
      logic [8:0] got;
      i_hpfg_host_model.hostRead(two, cd, got);
      chk(got, {1'b1, e});
   endtask : hostChk

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      rdPend <= regRead;
      cycles <= cycles + 1;
      if (rdPend)
         chk({1'b0, regRdata}, {1'b0, expQ.pop_front()});
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      logic [7:0]  d;
      logic [11:0] s;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(`HPFG_ADDR_STAT_ONE, 8'h00);
      rd(16'h0000, 8'h00);
      wr(`HPFG_ADDR_SYSCTL, 8'h02);
      wr(`HPFG_ADDR_GATE_PORT, 8'h03);
      wr(`HPFG_ADDR_CONTROL, 8'h03);
      @(posedge clk);
      chk({7'h00, gatePinOe, address_mask_gate_out}, 9'h003);
      d = xs();
      i_hpfg_host_model.hostWrite(1'b0, 1'b0, d, 1'b0);
      rd(`HPFG_ADDR_STAT_ONE, 8'h02);
      chk({8'h00, in_full_irq_one}, 9'h001);
      rd(`HPFG_ADDR_IN_ONE, d);
      rd(`HPFG_ADDR_STAT_ONE, 8'h00);
      foreach (STEPS[i]) begin
         s = STEPS[i];
         d = s[11] ? s[7:0] : ((xs() & 8'hfd) | s[7:0]);
         i_hpfg_host_model.hostWrite(1'b0, s[11], d, 1'b0);
         chk({7'h00, address_mask_gate_out, in_full_irq_one}, {7'h00, s[10:9]});
         if (s[9]) begin
            rd(`HPFG_ADDR_STAT_ONE, 8'h0a);
            rd(`HPFG_ADDR_IN_ONE, d);
         end
      end
      i_hpfg_host_model.hostWrite(1'b1, 1'b1, 8'hd1, 1'b0);
      d = xs() & 8'hfd;
      i_hpfg_host_model.hostWrite(1'b1, 1'b0, d, 1'b0);
      chk({7'h00, address_mask_gate_out, inFullIrqTwo}, 9'h003);
      rd(`HPFG_ADDR_STAT_TWO, 8'h02);
      rd(`HPFG_ADDR_IN_TWO, d);
      d = xs();
      wr(`HPFG_ADDR_OUT_ONE, d);
      wr(`HPFG_ADDR_OUT_TWO, ~d);
      rd(`HPFG_ADDR_STAT_TWO, 8'h01);
      hostChk(1'b0, 1'b1, 8'h01);
      hostChk(1'b0, 1'b0, d);
      hostChk(1'b0, 1'b1, 8'h00);
      hostChk(1'b1, 1'b1, 8'h01);
      hostChk(1'b1, 1'b0, ~d);
      rd(`HPFG_ADDR_STAT_TWO, 8'h00);
      i_hpfg_host_model.hostWrite(1'b0, 1'b0, 8'h5a, 1'b1);
      rd(`HPFG_ADDR_STAT_ONE, 8'h00);
      wr(`HPFG_ADDR_CONTROL, 8'h02);
      i_hpfg_host_model.hostWrite(1'b0, 1'b1, `HPFG_CMD_GATE, 1'b0);
      rd(`HPFG_ADDR_IN_ONE, `HPFG_CMD_GATE);
      d = xs() & 8'hfd;
      i_hpfg_host_model.hostWrite(1'b0, 1'b0, d, 1'b0);
      rd(`HPFG_ADDR_IN_ONE, d);
      wr(`HPFG_ADDR_GATE_PORT, {6'h00, d[1], 1'b1});
      repeat (2) @(posedge clk);
      chk({8'h00, address_mask_gate_out}, 9'h000);
      wr(`HPFG_ADDR_SYSCTL, 8'h00);
      i_hpfg_host_model.hostWrite(1'b0, 1'b1, 8'h33, 1'b0);
      rd(`HPFG_ADDR_STAT_ONE, 8'h00);
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule : hpfg_host_port_tb
`default_nettype wire
